/* design/ccadc_pkg.sv */
package ccadc_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CMD        = 8'h00;
  localparam logic [7:0] ADDR_CNT_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_CAL_CFG    = 8'h08;
  localparam logic [7:0] ADDR_EM_CTRL    = 8'h0C;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;
  localparam logic [7:0] ADDR_STAT_MASK  = 8'h14;
  localparam logic [7:0] ADDR_MODE       = 8'h18;
  localparam logic [7:0] ADDR_CONV_FORCE = 8'h1C;
  localparam logic [7:0] ADDR_ADC_CTRL   = 8'h20;
  localparam logic [7:0] ADDR_CNT_A_HI   = 8'h24;
  localparam logic [7:0] ADDR_CNT_A_LO   = 8'h28;
  localparam logic [7:0] ADDR_CNT_B0_HI  = 8'h2C;
  localparam logic [7:0] ADDR_CNT_B0_LO  = 8'h30;
  localparam logic [7:0] ADDR_CNT_B2_HI  = 8'h34;
  localparam logic [7:0] ADDR_CNT_B2_LO  = 8'h38;
  localparam logic [7:0] ADDR_CNT_C_HI   = 8'h3C;
  localparam logic [7:0] ADDR_CNT_C_LO   = 8'h40;
  localparam logic [7:0] ADDR_AVG_HI     = 8'h44;
  localparam logic [7:0] ADDR_AVG_LO     = 8'h48;
  localparam logic [7:0] ADDR_MIN_HI     = 8'h4C;
  localparam logic [7:0] ADDR_MIN_LO     = 8'h50;
  localparam logic [7:0] ADDR_MAX_HI     = 8'h54;
  localparam logic [7:0] ADDR_MAX_LO     = 8'h58;
  localparam logic [7:0] ADDR_TEMP_HI    = 8'h5C;
  localparam logic [7:0] ADDR_TEMP_LO    = 8'h60;

  // command register bits
  localparam int CMD_CAL_START = 0;
  localparam int CMD_CNT_CLR   = 1;
  localparam int CMD_ADC_CLEAR_CMD   = 2;

  // counter control fields
  localparam int CTL_EN     = 0;
  localparam int CTL_PRE_LO = 1;
  localparam int CTL_TH_LO  = 4;
  // calibration config fields
  localparam int CAL_SEL_LO = 0;
  localparam int CAL_REQ_LO = 2;
  localparam int CAL_LVL_LO = 10;
  // sleep control fields
  localparam int EM_SEL_LO  = 0;
  localparam int EM_CRS_LO  = 2;
  // adc control
  localparam int ADC_TAU_LO = 0;
  // status / mask bit
  localparam int ST_FULL    = 0;

  localparam int CNT_W   = 16;
  localparam int ADC_W   = 12;
  localparam int PRE_MAX = 8;
  localparam logic [ADC_W-1:0] MIN_RESET = 12'hFFF;
  localparam logic [ADC_W-1:0] MAX_RESET = 12'h000;

  // energy mode encodings
  typedef enum logic [1:0] {
    EM_ACTIVE = 2'h0,
    EM_LOWPWR = 2'h1,
    EM_DEEP   = 2'h2
  } ccadc_em_e;

  // supply configuration strap
  typedef enum logic [1:0] {
    CFG_NORMAL  = 2'h0,
    CFG_SC_BOOST = 2'h1,
    CFG_BOOTSTRAP = 2'h2
  } ccadc_cfg_e;

  // pulse inputs per output
  typedef struct packed {
    logic pulseA;
    logic pulseB;
    logic pulseC;
    logic ldoCActive; // ldo c carries load in parallel mode
    logic parallelMode;
  } ccadc_pulse_s;

  // one adc conversion result
  typedef struct packed {
    logic             valid;
    logic [ADC_W-1:0] volt;
    logic [ADC_W-1:0] temp;
  } ccadc_adc_s;

endpackage

/* design/ccadc_top.sv */
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module ccadc_top
  import ccadc_pkg::*;
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // measurement inputs
  input  wire ccadc_pulse_s pulses,
  input  wire logic         calTick,
  input  wire ccadc_adc_s   adcIn,
  input  wire logic [1:0]   convAModeIn,
  input  wire logic [1:0]   convBModeIn,
  input  wire logic         singleCell,
  input  wire ccadc_cfg_e   supplyCfg,
  input  wire logic         supplyAbove2v5,
  // power and status outputs
  output logic              convEnable,
  output logic [2:0]        coarseEnable,
  output logic              adcEnable,
  output logic              adcSelSupplyA,
  output logic [1:0]        calLoadSel,
  output logic [2:0]        calLoadLevel,
  output logic [1:0]        convAModeForce,
  output logic [1:0]        convBModeForce,
  output logic              irqReq
);

  // register state
  logic [7:0]       ctlR;
  logic [12:0]      calCfgR;
  logic [4:0]       emCtlR;
  logic [3:0]       forceR;
  logic [2:0]       tauR;
  logic             fullR, unmaskR;
  logic [CNT_W-1:0] cntA_r, cntB0_r, cntB2_r, cntC_r;
  logic [15:0]      preA_r, preB_r, preC_r;
  logic [ADC_W-1:0] avgR, minR, maxR, tempR;
  logic [ADC_W+7:0] avgAcc_r;
  logic [7:0]       shadowR;
  logic             adcClrPend_r;
  logic             calBusy_r;
  logic [7:0]       calPulses_r;
  logic [1:0]       emR;

  // bus decode
  logic acc, wr, rd;
  assign acc = psel & penable;
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;
  assign pready  = 1'b1;

  // prescaler field value
  logic [2:0] pre;
  assign pre = ctlR[CTL_PRE_LO +: 3];

  // step divider: 2^(16-2p) raw pulses per count
  function automatic logic [15:0] stepMask(input logic [2:0] p);
    logic [4:0] sh;
    sh = 5'd16 - {p, 1'b0};
    if (int'(p) >= PRE_MAX) stepMask = 16'h0000;
    else stepMask = 16'((32'h1 << sh) - 32'h1);
  endfunction

  // full threshold level in counts
  function automatic logic [CNT_W-1:0] thrLevel(input logic [1:0] t);
    case (t)
      2'h0:    thrLevel = 16'h8000;
      2'h1:    thrLevel = 16'hA000;
      2'h2:    thrLevel = 16'hC000;
      default: thrLevel = 16'hDEB8;
    endcase
  endfunction

  // prescaler tick: true when this pulse completes a count step
  function automatic logic stepDone(input logic [15:0] cnt,
                                    input logic [15:0] m);
    stepDone = (cnt & m) == m;
  endfunction

  // prescaler next value: wraps to zero on a completed step
  function automatic logic [15:0] stepNext(input logic [15:0] cnt,
                                           input logic [15:0] m);
    stepNext = stepDone(cnt, m) ? 16'h0000 : cnt + 16'h0001;
  endfunction

  // true while the bus addresses either half of a result pair
  function automatic logic pairSel(input logic s, input logic [7:0] a,
                                   input logic [7:0] hi,
                                   input logic [7:0] lo);
    pairSel = s && (a == hi || a == lo);
  endfunction

  // requested energy mode is filtered by supply configuration
  logic deepOk, deep, counting;
  assign deepOk = (supplyCfg == CFG_SC_BOOST) ? 1'b0 :
                  (supplyCfg == CFG_BOOTSTRAP) ? supplyAbove2v5 : 1'b1;
  assign deep = (emR == EM_DEEP);
  assign counting = ctlR[CTL_EN] & ~deep & ~calBusy_r;

  // energy mode register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) emR <= EM_ACTIVE;
    else if (emCtlR[EM_SEL_LO +: 2] == EM_DEEP && !deepOk) emR <= EM_LOWPWR;
    else emR <= ccadc_em_e'(emCtlR[EM_SEL_LO +: 2]);
  end

  // power gating outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      convEnable   <= 1'b1;
      coarseEnable <= 3'h0;
      adcEnable    <= 1'b1;
    end else begin
      convEnable   <= ~deep;
      coarseEnable <= deep ? emCtlR[EM_CRS_LO +: 3] : 3'h0;
      adcEnable    <= ~deep;
    end
  end

  // calibration and converter control outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      calLoadSel     <= 2'h0;
      calLoadLevel   <= 3'h0;
      convAModeForce <= 2'h0;
      convBModeForce <= 2'h0;
      adcSelSupplyA  <= 1'b0;
      irqReq         <= 1'b0;
    end else begin
      calLoadSel     <= calCfgR[CAL_SEL_LO +: 2];
      calLoadLevel   <= calBusy_r ? calCfgR[CAL_LVL_LO +: 3] : 3'h0;
      convAModeForce <= forceR[1:0];
      convBModeForce <= forceR[3:2];
      adcSelSupplyA  <= singleCell;
      irqReq         <= fullR & unmaskR & ~deep;
    end
  end

  // software-written registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctlR    <= 8'h00;
      calCfgR <= 13'h0000;
      emCtlR  <= 5'h00;
      forceR  <= 4'h0;
      tauR    <= 3'h0;
      unmaskR <= 1'b0;
    end else if (wr) begin
      case (paddr)
        ADDR_CNT_CTRL:   ctlR    <= pwdata[7:0];
        ADDR_CAL_CFG:    calCfgR <= pwdata[12:0];
        ADDR_EM_CTRL:    emCtlR  <= pwdata[4:0];
        ADDR_CONV_FORCE: forceR  <= pwdata[3:0];
        ADDR_ADC_CTRL:   tauR    <= pwdata[2:0];
        ADDR_STAT_MASK:  unmaskR <= pwdata[ST_FULL];
        default:         ;
      endcase
    end
  end

  // command strobes
  logic cmdWr, calStart, cntClr, adcClr;
  assign cmdWr    = wr && paddr == ADDR_CMD;
  assign calStart = cmdWr & pwdata[CMD_CAL_START];
  assign cntClr   = cmdWr & pwdata[CMD_CNT_CLR];
  assign adcClr   = cmdWr & pwdata[CMD_ADC_CLEAR_CMD];

  // selected pulse stream for calibration
  logic calPulse;
  always_comb begin
    case (calCfgR[CAL_SEL_LO +: 2])
      2'h0:    calPulse = pulses.pulseA;
      2'h1:    calPulse = pulses.pulseB;
      default: calPulse = pulses.pulseC;
    endcase
  end

  // calibration sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      calBusy_r   <= 1'b0;
      calPulses_r <= 8'h00;
    end else if (calStart && !deep) begin
      calBusy_r   <= 1'b1;
      calPulses_r <= 8'h00;
    end else if (calBusy_r && calPulse) begin
      calPulses_r <= calPulses_r + 8'h01;
      if (calPulses_r + 8'h01 >= calCfgR[CAL_REQ_LO +: 8])
        calBusy_r <= 1'b0;
    end
  end

  // pulse crediting, parallel mode split
  logic creditA, creditC, creditB0, creditB2;
  assign creditA  = counting & pulses.pulseA &
                    ~(pulses.parallelMode & pulses.ldoCActive);
  assign creditC  = counting & (pulses.pulseC |
                    (pulses.pulseA & pulses.parallelMode &
                     pulses.ldoCActive));
  assign creditB0 = counting & pulses.pulseB & (emR == EM_ACTIVE);
  assign creditB2 = counting & pulses.pulseB & (emR == EM_LOWPWR);

  // prescaled counters; calibration retasks output_c pair
  logic [15:0] msk;
  assign msk = stepMask(pre);
  always_ff @(posedge clk_sys) begin
    if (!rst_n || cntClr) begin
      cntA_r <= '0; cntB0_r <= '0; cntB2_r <= '0; cntC_r <= '0;
      preA_r <= '0; preB_r <= '0; preC_r <= '0;
    end else if (calStart && !deep) begin
      cntC_r <= '0;
    end else if (calBusy_r) begin
      if (calTick) cntC_r <= cntC_r + 16'h0001;
    end else begin
      if (creditA) begin
        preA_r <= stepNext(preA_r, msk);
        if (stepDone(preA_r, msk)) cntA_r <= cntA_r + 16'h0001;
      end
      if (creditB0 | creditB2) begin
        preB_r <= stepNext(preB_r, msk);
        if (stepDone(preB_r, msk)) begin
          if (creditB0) cntB0_r <= cntB0_r + 16'h0001;
          else          cntB2_r <= cntB2_r + 16'h0001;
        end
      end
      if (creditC) begin
        preC_r <= stepNext(preC_r, msk);
        if (stepDone(preC_r, msk)) cntC_r <= cntC_r + 16'h0001;
      end
    end
  end

  // fill flag, set wins over clear
  logic [CNT_W-1:0] thr;
  logic fullHit;
  assign thr = thrLevel(ctlR[CTL_TH_LO +: 2]);
  assign fullHit = ~calBusy_r & ((cntA_r >= thr) | (cntB0_r >= thr) |
                   (cntB2_r >= thr) | (cntC_r >= thr));
  always_ff @(posedge clk_sys) begin
    if (!rst_n) fullR <= 1'b0;
    else if (fullHit) fullR <= 1'b1;
    else if (wr && paddr == ADDR_STATUS && pwdata[ST_FULL]) fullR <= 1'b0;
  end

  // adc results; addressed register pair is frozen
  logic conv, lockAvg, lockMin, lockMax, lockTemp;
  logic [ADC_W+7:0] accNext;
  assign conv = adcIn.valid & ~deep;
  assign lockAvg  = pairSel(psel, paddr, ADDR_AVG_HI, ADDR_AVG_LO);
  assign lockMin  = pairSel(psel, paddr, ADDR_MIN_HI, ADDR_MIN_LO);
  assign lockMax  = pairSel(psel, paddr, ADDR_MAX_HI, ADDR_MAX_LO);
  assign lockTemp = pairSel(psel, paddr, ADDR_TEMP_HI, ADDR_TEMP_LO);
  assign accNext  = avgAcc_r - (avgAcc_r >> tauR) +
                    ({8'h00, adcIn.volt} << (5'd8 - {2'b00, tauR}) >> 0);

  // adc clear pending flag, set wins over consume
  always_ff @(posedge clk_sys) begin
    if (!rst_n) adcClrPend_r <= 1'b1;
    else if (adcClr) adcClrPend_r <= 1'b1;
    else if (conv) adcClrPend_r <= 1'b0;
  end

  // iir accumulator holds avg scaled by 2^8
  always_ff @(posedge clk_sys) begin
    if (!rst_n) avgAcc_r <= '0;
    else if (conv && adcClrPend_r && !adcClr)
      avgAcc_r <= {adcIn.volt, 8'h00};
    else if (conv) avgAcc_r <= accNext;
  end

  // visible result registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avgR <= '0; minR <= MIN_RESET; maxR <= MAX_RESET; tempR <= '0;
    end else if (conv) begin
      if (!lockTemp) tempR <= adcIn.temp;
      if (adcClrPend_r && !adcClr) begin
        if (!lockAvg) avgR <= adcIn.volt;
        if (!lockMin) minR <= adcIn.volt;
        if (!lockMax) maxR <= adcIn.volt;
      end else begin
        if (!lockAvg) avgR <= accNext[ADC_W+7:8];
        if (!lockMin && adcIn.volt < minR) minR <= adcIn.volt;
        if (!lockMax && adcIn.volt > maxR) maxR <= adcIn.volt;
      end
    end
  end

  // upper-part read captures the lower byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) shadowR <= 8'h00;
    else if (rd) begin
      case (paddr)
        ADDR_AVG_HI:  shadowR <= avgR[7:0];
        ADDR_MIN_HI:  shadowR <= minR[7:0];
        ADDR_MAX_HI:  shadowR <= maxR[7:0];
        ADDR_TEMP_HI: shadowR <= tempR[7:0];
        default:      ;
      endcase
    end
  end

  // read mux, registered
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      case (paddr)
        ADDR_CMD:        prdata <= {31'h0, calBusy_r};
        ADDR_CNT_CTRL:   prdata <= {24'h0, ctlR};
        ADDR_CAL_CFG:    prdata <= {19'h0, calCfgR};
        ADDR_EM_CTRL:    prdata <= {27'h0, emCtlR};
        ADDR_STATUS:     prdata <= {31'h0, fullR};
        ADDR_STAT_MASK:  prdata <= {31'h0, unmaskR};
        ADDR_MODE:       prdata <= {27'h0, singleCell,
                                    convBModeIn, convAModeIn};
        ADDR_CONV_FORCE: prdata <= {28'h0, forceR};
        ADDR_ADC_CTRL:   prdata <= {29'h0, tauR};
        ADDR_CNT_A_HI:   prdata <= {24'h0, cntA_r[15:8]};
        ADDR_CNT_A_LO:   prdata <= {24'h0, cntA_r[7:0]};
        ADDR_CNT_B0_HI:  prdata <= {24'h0, cntB0_r[15:8]};
        ADDR_CNT_B0_LO:  prdata <= {24'h0, cntB0_r[7:0]};
        ADDR_CNT_B2_HI:  prdata <= {24'h0, cntB2_r[15:8]};
        ADDR_CNT_B2_LO:  prdata <= {24'h0, cntB2_r[7:0]};
        ADDR_CNT_C_HI:   prdata <= {24'h0, cntC_r[15:8]};
        ADDR_CNT_C_LO:   prdata <= {24'h0, cntC_r[7:0]};
        ADDR_AVG_HI:     prdata <= {28'h0, avgR[11:8]};
        ADDR_MIN_HI:     prdata <= {28'h0, minR[11:8]};
        ADDR_MAX_HI:     prdata <= {28'h0, maxR[11:8]};
        ADDR_TEMP_HI:    prdata <= {28'h0, tempR[11:8]};
        ADDR_AVG_LO, ADDR_MIN_LO,
        ADDR_MAX_LO, ADDR_TEMP_LO:
                         prdata <= {24'h0, shadowR};
        default: begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

endmodule

/* testbench/ccadc_chk.sv */
`timescale 1ns/1ps
module ccadc_chk
  import ccadc_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // status
  input wire logic        singleCell,
  input wire ccadc_cfg_e  supplyCfg,
  input wire logic        convEnable,
  input wire logic        adcEnable,
  input wire logic        adcSelSupplyA,
  input wire logic [1:0]  calLoadSel,
  input wire logic [2:0]  calLoadLevel,
  input wire logic        irqReq
);
  logic maskR_r;
  wire  accPh   = psel && penable;
  wire  badAddr = paddr > ADDR_TEMP_LO || paddr[1:0] != 2'h0;
  // tracks the unmask bit as last written
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      maskR_r <= 1'b0;
    else if (accPh && pwrite && paddr == ADDR_STAT_MASK)
      maskR_r <= pwdata[ST_FULL];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; accPh && !pwrite && badAddr |-> pslverr && prdata == 0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped read");
  property p_ok; accPh && !badAddr |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped error");
  property p_sleepAdc; !convEnable |-> !adcEnable; endproperty
  a_sleepAdc: assert property (p_sleepAdc) else $error("adc on");
  property p_sleepIrq; !convEnable |-> !irqReq; endproperty
  a_sleepIrq: assert property (p_sleepIrq) else $error("irq sleep");
  property p_boost; (supplyCfg == CFG_SC_BOOST) [*4] |-> convEnable;
  endproperty
  a_boost: assert property (p_boost) else $error("boost sleep");
  property p_selA; $past(rst_n) |-> adcSelSupplyA == $past(singleCell);
  endproperty
  a_selA: assert property (p_selA) else $error("adc input");
  property p_calSel;
    calLoadLevel != 0 ##1 calLoadLevel != 0 |-> $stable(calLoadSel);
  endproperty
  a_calSel: assert property (p_calSel) else $error("cal sel");
  property p_irq; irqReq |-> maskR_r || $past(maskR_r); endproperty
  a_irq: assert property (p_irq) else $error("irq masked");
  c_cal: cover property (calLoadLevel != 0);
  c_sleep: cover property (!convEnable);
  c_bad: cover property (accPh && badAddr);
endmodule

bind ccadc_top ccadc_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .singleCell(singleCell),
  .supplyCfg(supplyCfg), .convEnable(convEnable), .adcEnable(adcEnable),
  .adcSelSupplyA(adcSelSupplyA), .calLoadSel(calLoadSel),
  .calLoadLevel(calLoadLevel), .irqReq(irqReq)
);

/* testbench/ccadc_front.sv */
`timescale 1ns/1ps
module ccadc_front
  import ccadc_pkg::*;
(
  // clock
  input wire logic     clk_sys,
  // measurement side
  output ccadc_pulse_s pulses,
  output logic         calTick,
  output ccadc_adc_s   adcIn
);
  // quiet front end at time zero
  initial begin
    pulses = '0;
    calTick = 1'b0;
    adcIn = '0;
  end
  // n one-cycle pulses on output k (0 a, 1 b, 2 c)
  task automatic pulse(input int k, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      pulses.pulseA <= k == 0;
      pulses.pulseB <= k == 1;
      pulses.pulseC <= k == 2;
      @(posedge clk_sys);
      pulses.pulseA <= 1'b0;
      pulses.pulseB <= 1'b0;
      pulses.pulseC <= 1'b0;
    end
  endtask
  // n periods of the 12.5 MHz reference
  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      calTick <= 1'b1;
      @(posedge clk_sys);
      calTick <= 1'b0;
    end
  endtask
  // which source carries the load in parallel mode
  task automatic par(input logic p, input logic l);
    @(posedge clk_sys);
    pulses.parallelMode <= p;
    pulses.ldoCActive <= l;
  endtask
  // one conversion result
  task automatic conv(input logic [11:0] v, input logic [11:0] t);
    @(posedge clk_sys);
    adcIn <= {1'b1, v, t};
    @(posedge clk_sys);
    adcIn.valid <= 1'b0;
  endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb
  import ccadc_pkg::*;
;
  logic         clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic         singleCell, supplyAbove2v5, convEnable, adcEnable;
  logic         adcSelSupplyA, irqReq;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [1:0]   convAModeIn, convBModeIn, convAModeForce, convBModeForce;
  logic [1:0]   calLoadSel;
  logic [2:0]   coarseEnable, calLoadLevel;
  ccadc_cfg_e   supplyCfg;
  ccadc_pulse_s pulses;
  ccadc_adc_s   adcIn;
  logic         calTick;
  int           n_mismatch, check_count, k;

  ccadc_front fe (.clk_sys(clk_sys), .pulses(pulses), .calTick(calTick),
    .adcIn(adcIn));
  ccadc_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .pulses(pulses),
    .calTick(calTick), .adcIn(adcIn), .convAModeIn(convAModeIn),
    .convBModeIn(convBModeIn), .singleCell(singleCell),
    .supplyCfg(supplyCfg), .supplyAbove2v5(supplyAbove2v5),
    .convEnable(convEnable), .coarseEnable(coarseEnable),
    .adcEnable(adcEnable), .adcSelSupplyA(adcSelSupplyA),
    .calLoadSel(calLoadSel), .calLoadLevel(calLoadLevel),
    .convAModeForce(convAModeForce), .convBModeForce(convBModeForce),
    .irqReq(irqReq));

  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic die();
    n_mismatch++;
    print_verdict();
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 16) die();
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string n);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask
  // upper nibble read first, then the shadowed lower byte
  task automatic rpair(input logic [7:0] a, input logic [11:0] v,
                       input string n);
    rchk(a, {28'h0, v[11:8]}, n);
    rchk(a + 8'h04, {24'h0, v[7:0]}, n);
  endtask
  task automatic sleep(input logic [31:0] d);
    wr(ADDR_EM_CTRL, d);
    repeat (3) @(posedge clk_sys);
  endtask

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {convAModeIn, convBModeIn, singleCell, supplyAbove2v5} = '0;
    supplyCfg = CFG_NORMAL;
    rst_n = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk(ADDR_CNT_CTRL, 32'h0, "ctrl");
    rpair(ADDR_MIN_HI, MIN_RESET, "minrst");
    rpair(ADDR_MAX_HI, MAX_RESET, "maxrst");
    $display("test reset done");
    wr(ADDR_CNT_CTRL, 32'hD);
    fe.pulse(0, 32);
    rchk(ADDR_CNT_A_LO, 32'h2, "pre6");
    wr(ADDR_CNT_CTRL, 32'hF);
    fe.pulse(0, 40);
    rchk(ADDR_CNT_A_LO, 32'hC, "pre7");
    wr(ADDR_CNT_CTRL, 32'hE);
    fe.pulse(0, 8);
    rchk(ADDR_CNT_A_LO, 32'hC, "off");
    wr(ADDR_CNT_CTRL, 32'hF);
    wr(ADDR_EM_CTRL, 32'h1);
    fe.pulse(1, 8);
    rchk(ADDR_CNT_B2_LO, 32'h2, "b2");
    wr(ADDR_EM_CTRL, 32'h0);
    fe.pulse(1, 4);
    rchk(ADDR_CNT_B0_LO, 32'h1, "b0");
    fe.par(1'b1, 1'b1);
    fe.pulse(0, 4);
    rchk(ADDR_CNT_C_LO, 32'h1, "parc");
    fe.par(1'b1, 1'b0);
    fe.pulse(0, 4);
    rchk(ADDR_CNT_A_LO, 32'hD, "para");
    fe.par(1'b0, 1'b0);
    wr(ADDR_CMD, 32'h2);
    rchk(ADDR_CNT_A_LO, 32'h0, "clra");
    rchk(ADDR_CNT_B2_LO, 32'h0, "clrb");
    $display("test count done");
    wr(ADDR_CNT_CTRL, 32'hE);
    wr(ADDR_CAL_CFG, 32'h1412);
    wr(ADDR_CMD, 32'h1);
    for (k = 0; k < 50 && calLoadLevel === 3'h0; k++) @(posedge clk_sys);
    `CHK("load", 3'h5, calLoadLevel)
    `CHK("lsel", 2'h2, calLoadSel)
    repeat (4) begin
      fe.ticks(5);
      fe.pulse(2, 1);
    end
    for (k = 0; k < 200; k++) begin
      apb(1'b0, ADDR_CMD, 32'h0);
      if (rd[CMD_CAL_START] === 1'b0) break;
    end
    if (k == 200) die();
    rchk(ADDR_CNT_C_LO, 32'h14, "cal");
    rchk(ADDR_CNT_C_HI, 32'h0, "calhi");
    `CHK("unload", 3'h0, calLoadLevel)
    $display("test cal done");
    convAModeIn <= 2'h2;
    convBModeIn <= 2'h1;
    singleCell <= 1'b1;
    rchk(ADDR_MODE, 32'h16, "mode");
    wr(ADDR_CONV_FORCE, 32'h9);
    repeat (2) @(posedge clk_sys);
    `CHK("forcea", 2'h1, convAModeForce)
    `CHK("forceb", 2'h2, convBModeForce)
    `CHK("supa", 1'b1, adcSelSupplyA)
    fe.conv(12'h123, 12'h456);
    rpair(ADDR_AVG_HI, 12'h123, "avg");
    rpair(ADDR_MAX_HI, 12'h123, "max1");
    rpair(ADDR_TEMP_HI, 12'h456, "temp");
    fe.conv(12'h2CD, 12'h0);
    fe.conv(12'h0EF, 12'h0);
    rpair(ADDR_MAX_HI, 12'h2CD, "max");
    rpair(ADDR_MIN_HI, 12'h0EF, "min");
    rchk(ADDR_MAX_LO, 32'hEF, "shadow");
    wr(ADDR_CMD, 32'h4);
    fe.conv(12'h777, 12'h0);
    rpair(ADDR_MIN_HI, 12'h777, "clrmin");
    rpair(ADDR_MAX_HI, 12'h777, "clrmax");
    $display("test adc done");
    wr(ADDR_CNT_CTRL, 32'hF);
    sleep(32'h16);
    `CHK("conv", 1'b0, convEnable)
    `CHK("coarse", 3'h5, coarseEnable)
    `CHK("adc", 1'b0, adcEnable)
    fe.pulse(0, 8);
    fe.conv(12'h100, 12'h0);
    rchk(ADDR_CNT_CTRL, 32'hF, "sleeprd");
    `CHK("irq", 1'b0, irqReq)
    sleep(32'h0);
    `CHK("wake", 1'b1, convEnable)
    rchk(ADDR_CNT_A_LO, 32'h0, "nocnt");
    rpair(ADDR_MIN_HI, 12'h777, "noadc");
    supplyCfg <= CFG_SC_BOOST;
    sleep(32'h16);
    `CHK("boost", 1'b1, convEnable)
    supplyCfg <= CFG_BOOTSTRAP;
    sleep(32'h16);
    `CHK("boot", 1'b1, convEnable)
    supplyAbove2v5 <= 1'b1;
    sleep(32'h16);
    `CHK("boothi", 1'b0, convEnable)
    sleep(32'h0);
    supplyCfg <= CFG_NORMAL;
    $display("test sleep done");
    wr(ADDR_STAT_MASK, 32'h1);
    rchk(ADDR_STAT_MASK, 32'h1, "mask");
    `CHK("noflag", 1'b0, irqReq)
    apb(1'b0, 8'h64, 32'h0);
    `CHK("badrd", 32'h0, rd)
    `CHK("baderr", 1'b1, pslverr)
    $display("test bus done");
    wr(ADDR_STAT_MASK, 32'h0);
    wr(ADDR_CNT_CTRL, 32'hE);
    wr(ADDR_CAL_CFG, 32'h1406);
    wr(ADDR_CMD, 32'h1);
    fe.ticks(32768);
    fe.pulse(2, 1);
    rchk(ADDR_STATUS, 32'h1, "full");
    rchk(ADDR_CNT_C_HI, 32'h80, "fullc");
    `CHK("masked", 1'b0, irqReq)
    wr(ADDR_STAT_MASK, 32'h1);
    repeat (2) @(posedge clk_sys);
    `CHK("irqon", 1'b1, irqReq)
    sleep(32'h16);
    `CHK("irqsleep", 1'b0, irqReq)
    sleep(32'h0);
    `CHK("irqwake", 1'b1, irqReq)
    wr(ADDR_CMD, 32'h2);
    rchk(ADDR_CNT_C_HI, 32'h0, "clrc");
    wr(ADDR_STATUS, 32'h1);
    repeat (2) @(posedge clk_sys);
    `CHK("irqoff", 1'b0, irqReq)
    $display("test full done");
    print_verdict();
  end
endmodule
